// [data_path_model.sv]
/*
 Local data path model feeding the port: phase and sector pulses, buffer data.
 Assumes the bench calls its tasks between clock edges.
*/
`timescale 1ns/1ns
module data_path_model (
  input wire logic clk_in,
  output logic [15:0] buf_rdata_out,
  output logic buf_data_ready_out,
  output logic data_phase_req_out,
  output logic sector_done_out
);
  initial {buf_rdata_out, buf_data_ready_out, data_phase_req_out, sector_done_out} = '0;
  // Not ready: data toggles so stale values never look valid
  always @(posedge clk_in) begin
    if (!buf_data_ready_out) begin
      buf_rdata_out <= ~buf_rdata_out;
    end
  end
  task automatic pulse(input logic phase);
    @(posedge clk_in);
    data_phase_req_out <= phase;
    sector_done_out <= !phase;
    @(posedge clk_in);
    data_phase_req_out <= 1'b0;
    sector_done_out <= 1'b0;
    #1;
  endtask
endmodule // data_path_model

// [host_taskfile_port.sv]
/*
 Host task-file port: firmware-side APB register file, host-side task-file reads,
 command-write effects, busy/interrupt/data-request control and channel-ready hold.
 Assumes host strobes are synchronous one-cycle-per-access level strobes on clk_in.
*/
// The APB slave port was chosen for this implementation.
// Function
// RULE1: Error bit 6 flags ECC syndrome; corrected continues, uncorrected ends command.
// RULE2: Error bit 7 flags bad track; command terminates.
// RULE3: Sector count, sector, cylinder bytes are firmware-written, host-read after command.
// RULE4: Size/drive/head and internal control clear on reset or host soft reset.
// RULE5: Size/drive/head holds head, drive, sector size and check-field select.
// RULE6: Check-field select one means ECC field, zero means CRC field.
// RULE7: Status bit 0 sets host error bit; host command write clears it.
// RULE8: Status bit 2 shows ECC correction; host command write clears it.
// RULE9: Firmware writes zero to reserved status and error bits.
// RULE10: Command matching either busy-exempt nibble does not raise busy.
// RULE11: Firmware loads busy-exempt nibbles before any host command.
// RULE12: Block count gives sectors moved per interrupt without firmware help.
// RULE13: Auto mode raises interrupt and clears busy when data is ready.
// RULE14: ECC byte count equals control bits 2:0 plus one.
// RULE15: Wait-status mode holds next data phase until host reads status.
// RULE16: Status-clear mode clears error and status at command start.
// RULE17: Word mode gives 16-bit data; otherwise 8-bit and no 16-bit indication.
// RULE18: Auto transfer raises data request at once on write or format.
// RULE19: Pre-ready mode drops channel ready while data register selected, not ready.
// RULE20: Command write with host drive bit zero sets drive-0 seek complete.
// RULE21: Hold count 0..7 reference clocks; reference is clock or half.
// RULE22: Firmware values reach host reads by the next host read cycle.
`timescale 1ns/1ns
`include "taskfile_regs.svh"

module host_taskfile_port (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic host_cs0_in,
  input wire logic host_cs1_in,
  input wire logic [2:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [15:0] host_wdata_in,
  output logic [15:0] host_rdata_out,
  output logic host_intrq_out,
  output logic host_io_cs16_out,
  output logic host_chrdy_out,
  input wire logic [15:0] buf_rdata_in,
  input wire logic buf_data_ready_in,
  input wire logic data_phase_req_in,
  input wire logic sector_done_in,
  output logic [15:0] buf_wdata_out,
  output logic buf_wr_out,
  output logic buf_rd_out,
  output logic drq_out,
  output logic busy_out,
  output logic ecc_field_out,
  output logic [3:0] ecc_byte_count_out,
  output logic cmd_strobe_out,
  output logic [7:0] cmd_opcode_out,
  output logic cmd_terminate_out
);

  // ===========================================================
  // State
  taskfile_pkg::byte_t err_q, err_d, scnt_q, scnt_d, snum_q, snum_d;
  taskfile_pkg::byte_t cyl_lo_q, cyl_lo_d, cyl_hi_q, cyl_hi_d, sdh_q, sdh_d;
  taskfile_pkg::byte_t sts_q, sts_d, exempt_q, exempt_d, blk_q, blk_d;
  taskfile_pkg::byte_t ctl_q, ctl_d, drv_q, drv_d, add_q, add_d, opcode_q, opcode_d;
  logic host_drv_q, host_drv_d, busy_q, busy_d, drq_q, drq_d, intrq_q, intrq_d;
  logic sts_seen_q, sts_seen_d, pend_q, pend_d, term_q, term_d, cmd_q, cmd_d;
  logic [6:0] sect_cnt_q, sect_cnt_d;
  logic [2:0] hold_q, hold_d;
  logic ref_div_q, ref_div_d, sel_nrdy_q, sel_nrdy_d;
  logic [31:0] prdata_q, prdata_d;
  logic [15:0] hrdata_q, hrdata_d;

  // ===========================================================
  // Decode helpers
  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
  endfunction

  function automatic logic cmd_exempt(input logic [7:0] op, input logic [7:0] pair);
    cmd_exempt = (op[7:4] == pair[7:4]) || (op[7:4] == pair[3:0]);
  endfunction

  logic apb_wr, apb_setup, hcmd_wr, hsrst, hsts_rd, hdata_sel, start_phase, block_end;
  logic [7:0] wbyte;
  logic [7:0] host_status;
  logic mapped;

  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_setup = psel_in && !penable_in;
  assign wbyte = pwdata_in[7:0];
  assign hcmd_wr = host_cs0_in && host_wr_in && (host_addr_in == taskfile_pkg::HREG_STATUS);
  assign hsrst = host_cs1_in && host_wr_in && (host_addr_in == taskfile_pkg::HREG_SDH)
    && host_wdata_in[`HOST_SRST_BIT];
  assign hsts_rd = host_cs0_in && host_rd_in && (host_addr_in == taskfile_pkg::HREG_STATUS);
  assign hdata_sel = host_cs0_in && (host_addr_in == taskfile_pkg::HREG_DATA);
  // Data phase may start only once status has been read when waiting is on
  assign start_phase = (data_phase_req_in || pend_q)
    && (!ctl_q[`CTL_WAIT_STS_BIT] || sts_seen_q || hsts_rd); // RULE15
  // Zero block count treated as one sector per interrupt
  assign block_end = sector_done_in && drq_q
    && ((sect_cnt_q + 7'h01 >= blk_q[6:0]) || (blk_q[6:0] == 7'h00)); // RULE12

  always_comb begin
    host_status = 8'h00;
    host_status[`HST_BUSY] = busy_q;
    host_status[`HST_READY] = 1'b1;
    host_status[`HST_SEEK] = host_drv_q ? drv_q[`DRV_SEEK1_BIT] : drv_q[`DRV_SEEK0_BIT];
    host_status[`HST_DRQ] = drq_q;
    host_status[`STS_CORR_BIT] = sts_q[`STS_CORR_BIT];
    host_status[`STS_ERR_BIT] = sts_q[`STS_ERR_BIT];
  end

  // ===========================================================
  // APB read decode, answered in the setup cycle so data is registered
  always_comb begin
    mapped = 1'b1;
    prdata_d = prdata_q;
    if (apb_setup) begin
      prdata_d = 32'h0000_0000;
      if (reg_hit(paddr_in, `IDX_ERROR_SRC)) prdata_d[7:0] = err_q;
      else if (reg_hit(paddr_in, `IDX_SECTOR_COUNT)) prdata_d[7:0] = scnt_q;
      else if (reg_hit(paddr_in, `IDX_FAIL_SECTOR)) prdata_d[7:0] = snum_q;
      else if (reg_hit(paddr_in, `IDX_FAIL_CYL_LO)) prdata_d[7:0] = cyl_lo_q;
      else if (reg_hit(paddr_in, `IDX_FAIL_CYL_HI)) prdata_d[7:0] = cyl_hi_q;
      else if (reg_hit(paddr_in, `IDX_SDH_RESULT)) prdata_d[7:0] = sdh_q;
      else if (reg_hit(paddr_in, `IDX_STATUS_SRC)) prdata_d[7:0] = sts_q;
      else if (reg_hit(paddr_in, `IDX_BUSY_EXEMPT)) prdata_d[7:0] = exempt_q;
      else if (reg_hit(paddr_in, `IDX_BLOCK_XFER)) prdata_d[7:0] = blk_q;
      else if (reg_hit(paddr_in, `IDX_INT_CTRL)) prdata_d[7:0] = ctl_q;
      else if (reg_hit(paddr_in, `IDX_DRIVE_CTRL)) prdata_d[7:0] = drv_q;
      else if (reg_hit(paddr_in, `IDX_ADD_CTRL)) prdata_d[7:0] = add_q;
      else if (reg_hit(paddr_in, `IDX_PORT_STATE)) prdata_d = {16'h0000, opcode_q, host_status};
    end
    if (!(reg_hit(paddr_in, `IDX_ERROR_SRC) || reg_hit(paddr_in, `IDX_SECTOR_COUNT)
        || reg_hit(paddr_in, `IDX_FAIL_SECTOR) || reg_hit(paddr_in, `IDX_FAIL_CYL_LO)
        || reg_hit(paddr_in, `IDX_FAIL_CYL_HI) || reg_hit(paddr_in, `IDX_SDH_RESULT)
        || reg_hit(paddr_in, `IDX_STATUS_SRC) || reg_hit(paddr_in, `IDX_BUSY_EXEMPT)
        || reg_hit(paddr_in, `IDX_BLOCK_XFER) || reg_hit(paddr_in, `IDX_INT_CTRL)
        || reg_hit(paddr_in, `IDX_DRIVE_CTRL) || reg_hit(paddr_in, `IDX_ADD_CTRL)
        || reg_hit(paddr_in, `IDX_PORT_STATE))) begin
      mapped = 1'b0;
    end
  end

  // ===========================================================
  // Task-file and control next state
  always_comb begin
    err_d = err_q;
    scnt_d = scnt_q;
    snum_d = snum_q;
    cyl_lo_d = cyl_lo_q;
    cyl_hi_d = cyl_hi_q;
    sdh_d = sdh_q;
    sts_d = sts_q;
    exempt_d = exempt_q;
    blk_d = blk_q;
    ctl_d = ctl_q;
    drv_d = drv_q;
    add_d = add_q;
    opcode_d = opcode_q;
    host_drv_d = host_drv_q;
    busy_d = busy_q;
    drq_d = drq_q;
    intrq_d = intrq_q;
    sts_seen_d = sts_seen_q;
    pend_d = pend_q;
    sect_cnt_d = sect_cnt_q;
    term_d = 1'b0;
    cmd_d = 1'b0;

    // Host events first and firmware writes after them; host soft reset is applied last and wins
    if (host_cs0_in && host_wr_in && (host_addr_in == taskfile_pkg::HREG_SDH)) begin
      host_drv_d = host_wdata_in[`HOST_HEAD_DRV_BIT];
    end
    if (hsts_rd) begin
      sts_seen_d = 1'b1;
      intrq_d = 1'b0;
    end
    if (hcmd_wr) begin
      cmd_d = 1'b1;
      opcode_d = host_wdata_in[7:0];
      sts_d[`STS_ERR_BIT] = 1'b0; // RULE7
      sts_d[`STS_CORR_BIT] = 1'b0; // RULE8
      sts_seen_d = 1'b0;
      pend_d = 1'b0;
      sect_cnt_d = 7'h00;
      intrq_d = 1'b0;
      drq_d = 1'b0;
      if (ctl_q[`CTL_STS_CLR_BIT]) begin
        err_d = `RST_ZERO; // RULE16
        sts_d = `RST_ZERO; // RULE16
      end
      busy_d = !cmd_exempt(host_wdata_in[7:0], exempt_q); // RULE10
      if (!host_drv_q) drv_d[`DRV_SEEK0_BIT] = 1'b1; // RULE20
      else drv_d[`DRV_SEEK1_BIT] = 1'b1;
      // Write and format commands open their data phase at once
      if (!ctl_q[`CTL_NO_AUTO_BIT] && ((host_wdata_in[7:4] == `OP_WRITE_HI)
          || (host_wdata_in[7:0] == `OP_FORMAT))) begin
        drq_d = 1'b1; // RULE18
      end
    end else begin
      if (data_phase_req_in && !start_phase) pend_d = 1'b1; // RULE15
      if (start_phase) begin
        pend_d = 1'b0;
        sts_seen_d = 1'b0;
        drq_d = 1'b1;
        sect_cnt_d = 7'h00;
        if (blk_q[`BLK_AUTO_BIT]) begin
          intrq_d = 1'b1; // RULE13
          busy_d = 1'b0; // RULE13
        end
      end else if (sector_done_in && drq_q) begin
        sect_cnt_d = sect_cnt_q + 7'h01; // RULE12
        if (block_end) begin
          drq_d = 1'b0; // RULE12
          sect_cnt_d = 7'h00;
          if (blk_q[`BLK_AUTO_BIT]) busy_d = 1'b1;
        end
      end
    end

    // Firmware register writes
    if (apb_wr) begin
      if (reg_hit(paddr_in, `IDX_ERROR_SRC)) begin
        err_d = wbyte & `ERR_WRITABLE_MASK; // RULE9
        // Bad track always ends the command
        if (wbyte[`ERR_BAD_TRACK_BIT]) term_d = 1'b1; // RULE2
      end
      if (reg_hit(paddr_in, `IDX_SECTOR_COUNT)) scnt_d = wbyte; // RULE3
      if (reg_hit(paddr_in, `IDX_FAIL_SECTOR)) snum_d = wbyte; // RULE3
      if (reg_hit(paddr_in, `IDX_FAIL_CYL_LO)) cyl_lo_d = wbyte; // RULE3
      if (reg_hit(paddr_in, `IDX_FAIL_CYL_HI)) cyl_hi_d = wbyte; // RULE3
      if (reg_hit(paddr_in, `IDX_SDH_RESULT)) sdh_d = wbyte; // RULE5
      if (reg_hit(paddr_in, `IDX_STATUS_SRC)) begin
        sts_d = wbyte & `STS_WRITABLE_MASK; // RULE7 RULE8
        // Uncorrected data error ends the command; a correction lets it run on
        if (wbyte[`STS_ERR_BIT] && err_q[`ERR_ECC_BIT]) term_d = 1'b1; // RULE1
      end
      if (reg_hit(paddr_in, `IDX_BUSY_EXEMPT)) exempt_d = wbyte;
      if (reg_hit(paddr_in, `IDX_BLOCK_XFER)) blk_d = wbyte;
      if (reg_hit(paddr_in, `IDX_INT_CTRL)) ctl_d = wbyte;
      if (reg_hit(paddr_in, `IDX_ADD_CTRL)) add_d = wbyte;
      if (reg_hit(paddr_in, `IDX_DRIVE_CTRL)) begin
        drv_d = wbyte;
        if (hcmd_wr && !host_drv_q) drv_d[`DRV_SEEK0_BIT] = 1'b1; // RULE20
        busy_d = wbyte[`DRV_BUSY_BIT];
        if (wbyte[`DRV_INTRQ_BIT]) begin
          intrq_d = 1'b1;
          busy_d = 1'b0;
        end
      end
    end
    if (term_d) begin
      busy_d = 1'b0;
      drq_d = 1'b0;
      pend_d = 1'b0;
    end
    if (hsrst) begin
      sdh_d = `RST_ZERO; // RULE4
      ctl_d = `RST_ZERO; // RULE4
      add_d = `RST_ZERO;
      busy_d = 1'b0;
      drq_d = 1'b0;
      intrq_d = 1'b0;
      pend_d = 1'b0;
    end
  end

  // ===========================================================
  // Host read path and channel-ready hold
  always_comb begin
    hrdata_d = hrdata_q;
    if (host_cs0_in && host_rd_in) begin
      hrdata_d = 16'h0000;
      unique case (taskfile_pkg::host_reg_e'(host_addr_in))
        taskfile_pkg::HREG_DATA: hrdata_d = ctl_q[`CTL_WORD_BIT] ? buf_rdata_in
          : {8'h00, buf_rdata_in[7:0]}; // RULE17
        taskfile_pkg::HREG_ERROR: hrdata_d[7:0] = err_q; // RULE22
        taskfile_pkg::HREG_SCOUNT: hrdata_d[7:0] = scnt_q; // RULE22
        taskfile_pkg::HREG_SNUM: hrdata_d[7:0] = snum_q; // RULE22
        taskfile_pkg::HREG_CYL_LO: hrdata_d[7:0] = cyl_lo_q; // RULE22
        taskfile_pkg::HREG_CYL_HI: hrdata_d[7:0] = cyl_hi_q; // RULE22
        taskfile_pkg::HREG_SDH: hrdata_d[7:0] = sdh_q; // RULE22
        taskfile_pkg::HREG_STATUS: hrdata_d[7:0] = host_status;
      endcase
    end
    // Reference is the clock itself or every other edge
    ref_div_d = !ref_div_q;
    sel_nrdy_d = hdata_sel && !buf_data_ready_in;
    hold_d = hold_q;
    if (ctl_q[`CTL_PRE_RDY_BIT] && hdata_sel && !buf_data_ready_in && !sel_nrdy_q) begin
      hold_d = add_q[7:5]; // RULE19 RULE21
    end else if ((hold_q != 3'h0) && (add_q[`ADD_REF_FULL_BIT] || ref_div_q)) begin
      hold_d = hold_q - 3'h1; // RULE21
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      err_q <= `RST_ZERO;
      scnt_q <= `RST_ZERO;
      snum_q <= `RST_ZERO;
      cyl_lo_q <= `RST_ZERO;
      cyl_hi_q <= `RST_ZERO;
      sdh_q <= `RST_ZERO; // RULE4
      sts_q <= `RST_ZERO;
      exempt_q <= `RST_ZERO;
      blk_q <= `RST_ZERO;
      ctl_q <= `RST_ZERO; // RULE4
      drv_q <= `RST_ZERO;
      add_q <= `RST_ZERO;
      opcode_q <= `RST_ZERO;
      host_drv_q <= 1'b0;
      busy_q <= 1'b0;
      drq_q <= 1'b0;
      intrq_q <= 1'b0;
      sts_seen_q <= 1'b0;
      pend_q <= 1'b0;
      term_q <= 1'b0;
      cmd_q <= 1'b0;
      sect_cnt_q <= 7'h00;
      hold_q <= 3'h0;
      ref_div_q <= 1'b0;
      sel_nrdy_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      hrdata_q <= 16'h0000;
    end else begin
      err_q <= err_d;
      scnt_q <= scnt_d;
      snum_q <= snum_d;
      cyl_lo_q <= cyl_lo_d;
      cyl_hi_q <= cyl_hi_d;
      sdh_q <= sdh_d;
      sts_q <= sts_d;
      exempt_q <= exempt_d;
      blk_q <= blk_d;
      ctl_q <= ctl_d;
      drv_q <= drv_d;
      add_q <= add_d;
      opcode_q <= opcode_d;
      host_drv_q <= host_drv_d;
      busy_q <= busy_d;
      drq_q <= drq_d;
      intrq_q <= intrq_d;
      sts_seen_q <= sts_seen_d;
      pend_q <= pend_d;
      term_q <= term_d;
      cmd_q <= cmd_d;
      sect_cnt_q <= sect_cnt_d;
      hold_q <= hold_d;
      ref_div_q <= ref_div_d;
      sel_nrdy_q <= sel_nrdy_d;
      prdata_q <= prdata_d;
      hrdata_q <= hrdata_d;
    end
  end

  // ===========================================================
  // Outputs
  assign prdata_out = prdata_q;
  // Zero wait states; unmapped words flag an error and write nothing
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign host_rdata_out = hrdata_q;
  assign host_intrq_out = intrq_q;
  assign host_io_cs16_out = hdata_sel && ctl_q[`CTL_WORD_BIT]; // RULE17
  assign host_chrdy_out = (hold_q == 3'h0); // RULE19
  assign buf_wdata_out = ctl_q[`CTL_WORD_BIT] ? host_wdata_in : {8'h00, host_wdata_in[7:0]}; // RULE17
  assign buf_wr_out = hdata_sel && host_wr_in;
  assign buf_rd_out = hdata_sel && host_rd_in;
  assign drq_out = drq_q;
  assign busy_out = busy_q;
  assign ecc_field_out = sdh_q[`SDH_CHECK_BIT]; // RULE6
  assign ecc_byte_count_out = {1'b0, ctl_q[2:0]} + 4'h1; // RULE14
  assign cmd_strobe_out = cmd_q;
  assign cmd_opcode_out = opcode_q;
  assign cmd_terminate_out = term_q;

endmodule // host_taskfile_port

// [host_taskfile_port_assertions.sv]
/*
 Checker for the host task-file port: relations between host strobes and outputs.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module host_taskfile_port_assertions (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic host_cs0_in,
  input wire logic host_cs1_in,
  input wire logic [2:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic [15:0] host_wdata_in,
  input wire logic buf_data_ready_in,
  input wire logic host_io_cs16_out,
  input wire logic host_chrdy_out,
  input wire logic [15:0] buf_wdata_out,
  input wire logic buf_wr_out,
  input wire logic drq_out,
  input wire logic busy_out,
  input wire logic host_intrq_out,
  input wire logic cmd_strobe_out,
  input wire logic [7:0] cmd_opcode_out,
  input wire logic cmd_terminate_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ===========================================================
  // Host strobe patterns
  sequence s_cmd;
    host_cs0_in && host_wr_in && host_addr_in == 3'h7;
  endsequence
  sequence s_soft;
    host_cs1_in && host_wr_in && host_addr_in == 3'h6 && host_wdata_in[2];
  endsequence
  sequence s_data_sel;
    host_cs0_in && host_addr_in == 3'h0;
  endsequence
  // ===========================================================
  // Properties
  a_cs16_select: assert property (host_io_cs16_out |-> s_data_sel)
    else $error("cs16 without data register select");
  a_buf_write: assert property (buf_wr_out |-> s_data_sel and host_wr_in)
    else $error("buffer write without host data write");
  a_byte_upper: assert property (buf_wr_out && !host_io_cs16_out |-> buf_wdata_out[15:8] == 8'h00)
    else $error("byte mode passed upper byte");
  a_cmd_capture: assert property (s_cmd |=> cmd_strobe_out && cmd_opcode_out == $past(host_wdata_in[7:0]))
    else $error("command not captured");
  a_soft_clear: assert property (s_soft |=> !busy_out && !drq_out && !host_intrq_out)
    else $error("soft reset left busy, drq or intrq");
  a_chrdy_cause: assert property ($fell(host_chrdy_out) |-> $past(host_cs0_in && host_addr_in == 3'h0
    && !buf_data_ready_in))
    else $error("channel ready dropped without cause");
  a_chrdy_bound: assert property (!host_chrdy_out |-> ##[1:16] host_chrdy_out)
    else $error("channel ready held too long");
  a_term_idle: assert property (cmd_terminate_out |-> ##[0:1] (!busy_out && !drq_out))
    else $error("terminate left busy or drq");
endmodule // host_taskfile_port_assertions

// [host_taskfile_port_tb.sv]
/*
 Bench for the host task-file port: APB firmware, host strobes, data path model.
 Assumes the register header, checker and model files are compiled first.
*/
`timescale 1ns/1ns
`include "taskfile_regs.svh"
module host_taskfile_port_tb;
  logic clk_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, q;
  logic host_cs0_in, host_cs1_in, host_wr_in, host_rd_in, host_intrq_out, host_io_cs16_out, host_chrdy_out;
  logic [2:0] host_addr_in;
  logic [15:0] host_wdata_in, host_rdata_out, buf_rdata_in, buf_wdata_out;
  logic buf_data_ready_in, data_phase_req_in, sector_done_in, buf_wr_out, buf_rd_out, drq_out, busy_out;
  logic ecc_field_out, cmd_strobe_out, cmd_terminate_out, e;
  logic [3:0] ecc_byte_count_out;
  logic [7:0] cmd_opcode_out;
  int n_fail = 0;
  int checks_done = 0;
  int lows;
  host_taskfile_port host_taskfile_port_inst (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .host_cs0_in, .host_cs1_in, .host_addr_in, .host_wr_in,
    .host_rd_in, .host_wdata_in, .host_rdata_out, .host_intrq_out, .host_io_cs16_out, .host_chrdy_out,
    .buf_rdata_in, .buf_data_ready_in, .data_phase_req_in, .sector_done_in, .buf_wdata_out, .buf_wr_out,
    .buf_rd_out, .drq_out, .busy_out, .ecc_field_out, .ecc_byte_count_out, .cmd_strobe_out, .cmd_opcode_out,
    .cmd_terminate_out);
  data_path_model data_path_model_inst (.clk_in, .buf_rdata_out(buf_rdata_in),
    .buf_data_ready_out(buf_data_ready_in), .data_phase_req_out(data_phase_req_in),
    .sector_done_out(sector_done_in));
  // ===========================================================
  // Bus and host helpers
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits for pready; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {2'b00, idx, 2'b00};
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic hs(input logic cs1, input logic [2:0] a, input logic w, input logic [15:0] d);
    @(posedge clk_in);
    host_cs0_in <= !cs1;
    host_cs1_in <= cs1;
    host_addr_in <= a;
    host_wr_in <= w;
    host_rd_in <= !w;
    host_wdata_in <= d;
    @(posedge clk_in);
    host_cs0_in <= 1'b0;
    host_cs1_in <= 1'b0;
    host_wr_in <= 1'b0;
    host_rd_in <= 1'b0;
    #1;
  endtask
  // ===========================================================
  // Scenarios
  task automatic t_regs;
    rd(`IDX_SDH_RESULT, 32'h0000_0000);
    rd(`IDX_INT_CTRL, 32'h0000_0000);
    apb(1'b0, 8'h60, 32'h0000_0000);
    chk({q[7:0], e}, 9'h001);
    apb(1'b1, `IDX_STATUS_SRC, 32'h0000_00FF);
    rd(`IDX_STATUS_SRC, 32'h0000_0005);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `IDX_INT_CTRL, i);
      chk(ecc_byte_count_out, i + 1);
    end
    apb(1'b1, `IDX_SDH_RESULT, 32'h0000_00DB);
    chk(ecc_field_out, 1'b1);
    hs(1'b1, 3'h6, 1'b1, 16'h0004);
    rd(`IDX_SDH_RESULT, 32'h0000_0000);
    rd(`IDX_INT_CTRL, 32'h0000_0000);
    chk(ecc_field_out, 1'b0);
    $display("done registers");
  endtask
  task automatic t_taskfile;
    logic [7:0] v[7] = '{8'h00, 8'h00, 8'h3C, 8'hA5, 8'h01, 8'hFE, 8'h5B};
    for (int i = 2; i < 7; i++) begin
      apb(1'b1, `IDX_SECTOR_COUNT + i - 2, v[i]);
      hs(1'b0, i, 1'b0, 16'h0000);
      chk(host_rdata_out[7:0], v[i]);
    end
    $display("done task file");
  endtask
  task automatic t_status;
    apb(1'b1, `IDX_STATUS_SRC, 32'h0000_0005);
    hs(1'b0, 3'h7, 1'b0, 16'h0000);
    chk(host_rdata_out[7:0], 8'h45);
    hs(1'b0, 3'h7, 1'b1, 16'h0020);
    chk({busy_out, cmd_strobe_out}, 2'b11);
    hs(1'b0, 3'h7, 1'b0, 16'h0000);
    chk(host_rdata_out[7:0], 8'hD0);
    rd(`IDX_DRIVE_CTRL, 32'h0000_0001);
    $display("done status");
  endtask
  task automatic t_exempt;
    apb(1'b1, `IDX_BUSY_EXEMPT, 32'h0000_009E);
    apb(1'b1, `IDX_DRIVE_CTRL, 32'h0000_0000);
    hs(1'b0, 3'h7, 1'b1, 16'h0091);
    chk(busy_out, 1'b0);
    hs(1'b0, 3'h7, 1'b1, 16'h00E5);
    chk(busy_out, 1'b0);
    hs(1'b0, 3'h7, 1'b1, 16'h0020);
    chk(busy_out, 1'b1);
    $display("done busy exempt");
  endtask
  task automatic t_auto;
    apb(1'b1, `IDX_DRIVE_CTRL, 32'h0000_0000);
    apb(1'b1, `IDX_BLOCK_XFER, 32'h0000_0082);
    apb(1'b1, `IDX_INT_CTRL, 32'h0000_0000);
    hs(1'b0, 3'h7, 1'b1, 16'h0030);
    chk({drq_out, busy_out}, 2'b11);
    data_path_model_inst.pulse(1'b1);
    chk({drq_out, host_intrq_out, busy_out}, 3'b110);
    data_path_model_inst.pulse(1'b0);
    chk(drq_out, 1'b1);
    data_path_model_inst.pulse(1'b0);
    chk({drq_out, busy_out}, 2'b01);
    apb(1'b1, `IDX_INT_CTRL, 32'h0000_0008);
    data_path_model_inst.pulse(1'b1);
    chk(drq_out, 1'b0);
    hs(1'b0, 3'h7, 1'b0, 16'h0000);
    chk(drq_out, 1'b1);
    $display("done auto transfer");
  endtask
  task automatic t_ready;
    hs(1'b0, 3'h0, 1'b1, 16'hABCD);
    apb(1'b1, `IDX_ADD_CTRL, 32'h0000_00F0);
    apb(1'b1, `IDX_INT_CTRL, 32'h0000_00A0);
    @(posedge clk_in);
    host_cs0_in <= 1'b1;
    host_addr_in <= 3'h0;
    host_rd_in <= 1'b1;
    #1;
    chk({host_io_cs16_out, buf_rd_out}, 2'b11);
    lows = 0;
    repeat (20) begin
      @(posedge clk_in);
      host_cs0_in <= 1'b0;
      host_rd_in <= 1'b0;
      #1;
      lows += (host_chrdy_out === 1'b0);
    end
    chk(lows, 7);
    $display("done channel ready");
  endtask
  task automatic t_error;
    apb(1'b1, `IDX_ERROR_SRC, 32'h0000_0040);
    apb(1'b1, `IDX_STATUS_SRC, 32'h0000_0004);
    chk(cmd_terminate_out, 1'b0);
    apb(1'b1, `IDX_STATUS_SRC, 32'h0000_0001);
    chk(cmd_terminate_out, 1'b1);
    apb(1'b1, `IDX_ERROR_SRC, 32'h0000_0080);
    chk(cmd_terminate_out, 1'b1);
    apb(1'b1, `IDX_INT_CTRL, 32'h0000_0010);
    hs(1'b0, 3'h7, 1'b1, 16'h0020);
    rd(`IDX_ERROR_SRC, 32'h0000_0000);
    $display("done error");
  endtask
  // ===========================================================
  // Run control
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {rst_b_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {host_cs0_in, host_cs1_in, host_addr_in, host_wr_in, host_rd_in, host_wdata_in} = '0;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_taskfile();
    t_status();
    t_exempt();
    t_auto();
    t_ready();
    t_error();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    wrap_up();
  end
endmodule // host_taskfile_port_tb
bind host_taskfile_port host_taskfile_port_assertions host_taskfile_port_assertions_inst (.clk_in, .rst_b_in,
  .host_cs0_in, .host_cs1_in, .host_addr_in, .host_wr_in, .host_wdata_in, .buf_data_ready_in, .host_io_cs16_out,
  .host_chrdy_out, .buf_wdata_out, .buf_wr_out, .drq_out, .busy_out, .host_intrq_out, .cmd_strobe_out,
  .cmd_opcode_out, .cmd_terminate_out);

// [taskfile_pkg.sv]
/*
 Types shared by the host task-file port.
 Assumes the register header supplies all numeric constants except the host register addresses defined here.
*/
package taskfile_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    HREG_DATA = 3'b000,
    HREG_ERROR = 3'b001,
    HREG_SCOUNT = 3'b010,
    HREG_SNUM = 3'b011,
    HREG_CYL_LO = 3'b100,
    HREG_CYL_HI = 3'b101,
    HREG_SDH = 3'b110,
    HREG_STATUS = 3'b111
  } host_reg_e;
endpackage

// [taskfile_regs.svh]
/*
 Register indices, field positions, reset values and codes of the host task-file port.
 Assumes the including file works on 8-bit register values and a 32-bit word bus.
*/
`ifndef TASKFILE_REGS_SVH
`define TASKFILE_REGS_SVH

// ===========================================================
// Register indices (byte address is four times the index)
`define IDX_ERROR_SRC 8'h41
`define IDX_SECTOR_COUNT 8'h42
`define IDX_FAIL_SECTOR 8'h43
`define IDX_FAIL_CYL_LO 8'h44
`define IDX_FAIL_CYL_HI 8'h45
`define IDX_SDH_RESULT 8'h46
`define IDX_STATUS_SRC 8'h47
`define IDX_BUSY_EXEMPT 8'h48
`define IDX_BLOCK_XFER 8'h49
`define IDX_INT_CTRL 8'h4A
`define IDX_DRIVE_CTRL 8'h4B
`define IDX_ADD_CTRL 8'h4D
`define IDX_PORT_STATE 8'h4E

// ===========================================================
// Field positions
`define ERR_ECC_BIT 6
`define ERR_BAD_TRACK_BIT 7
`define ERR_WRITABLE_MASK 8'hD7
`define STS_ERR_BIT 0
`define STS_CORR_BIT 2
`define STS_WRITABLE_MASK 8'h05
`define SDH_DRIVE_BIT 4
`define SDH_CHECK_BIT 7
`define BLK_AUTO_BIT 7
`define CTL_WAIT_STS_BIT 3
`define CTL_STS_CLR_BIT 4
`define CTL_WORD_BIT 5
`define CTL_NO_AUTO_BIT 6
`define CTL_PRE_RDY_BIT 7
`define DRV_SEEK0_BIT 0
`define DRV_SEEK1_BIT 3
`define DRV_INTRQ_BIT 6
`define DRV_BUSY_BIT 7
`define ADD_REF_FULL_BIT 4
`define HOST_SRST_BIT 2
`define HOST_HEAD_DRV_BIT 4

// ===========================================================
// Reset values and host status layout
`define RST_ZERO 8'h00
`define HST_BUSY 7
`define HST_READY 6
`define HST_SEEK 4
`define HST_DRQ 3

// ===========================================================
// Command opcodes that open a write-type data phase
`define OP_WRITE_HI 4'h3
`define OP_FORMAT 8'h50

`endif
